/* File: rtl/spp_pkg.sv */
// Package with constants for the serial peripheral port
package spp_pkg;
    localparam int SPP_WORD_BITS = 16;
    localparam int SPP_FIFO_DEPTH = 16;
    localparam int SPP_CTL_CONTROLLER_BIT = 0;
    localparam int SPP_FMT_PHASE_BIT = 16;
    localparam int SPP_FMT_POLARITY_BIT = 17;
    localparam int SPP_FMT_PRESCALE_LSB = 8;
    localparam int SPP_FMT_PRESCALE_MSB = 15;
    localparam int SPP_MIN_SCLK_PERIOD_NS = 25;
    localparam int SPP_CLK_PERIOD_NS = 8;
    localparam int SPP_MIN_SCLK_CYCLES =
        (SPP_MIN_SCLK_PERIOD_NS + SPP_CLK_PERIOD_NS - 1) / SPP_CLK_PERIOD_NS;
    localparam logic [15:0] SPP_TX_IDLE_WORD = 16'h0000;
    localparam logic [4:0] SPP_BIT_COUNT_RESET = 5'h00;
    localparam logic [4:0] SPP_BIT_COUNT_LAST = 5'h0f;
    typedef enum logic [2:0] {
        SPP_IDLE = 3'b001,
        SPP_LOAD = 3'b010,
        SPP_WAIT = 3'b100
    } spp_tx_state_type;
endpackage

/* File: rtl/spp_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module spp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Read side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] used;
    logic do_wr;
    logic do_rd;

    // Occupancy and handshakes
    assign used = wr_q - rd_q;
    assign in_ready = (used != DEPTH[AW:0]);
    assign out_valid = (used != '0);
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // Storage
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/spp_sync.sv */
// Two-flop synchroniser for a level
`timescale 1ns/100ps
`default_nettype none
module spp_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic level_in,
    output logic level_out
);
    logic meta_q;

    // Two flip-flops, first read only by second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_q <= level_in;
            level_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/spp_port.sv */
// Serial peripheral port: link-side shifter, crossings and receive FIFO
// Overview of operation
// - Acts as peripheral only while the controller-select bit is clear
// - Phase bit selects which serial clock edge launches and samples
// - Polarity bit selects the active serial clock edge
// - Data out changes after rising edge when polarity equals phase
// - Data in sampled on falling edge when polarity equals phase
`timescale 1ns/100ps
`default_nettype none
module spp_port (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration
    input wire logic ctl_controller_select,
    input wire logic fmt_clock_phase,
    input wire logic fmt_clock_polarity,
    input wire logic [7:0] prescale_value,
    // Link pins
    input wire logic serial_clock_pin,
    input wire logic chip_select_n,
    input wire logic peripheral_data_in,
    output logic peripheral_data_out,
    output logic peripheral_data_out_oe,
    // Transmit word from internal logic
    input wire logic [15:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Received words to internal logic
    output logic [15:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Status
    output logic rx_overrun,
    output logic peripheral_active
);
    import spp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset release and configuration crossing
    logic rst_a_q;
    logic rst_n_q;
    logic periph_en;
    logic phase_l;
    logic pol_l;
    logic unused_cfg;

    // Reset released through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    // Prescale only bounds the host clock, no logic uses it
    assign unused_cfg = ^prescale_value;
    assign periph_en = !ctl_controller_select;

    // Mode bits are static while a frame runs; link logic reads them directly
    assign phase_l = fmt_clock_phase;
    assign pol_l = fmt_clock_polarity;

    ////////////////////////////////////////////////////////////////////
    // Link domain: sample and launch edges
    logic samp_clk;
    logic launch_clk;
    logic frame_rst_n;
    logic [15:0] rx_shift_q;
    logic [4:0] rx_cnt_q;
    logic [15:0] rx_word_q;
    logic rx_tgl_q;
    logic [15:0] tx_shift_q;
    logic tx_take_tgl_q;
    logic [15:0] tx_hold_q;
    logic [4:0] tx_cnt_q;

    // Sample on rising when polarity differs from phase, else falling
    assign samp_clk = serial_clock_pin ^ ~(pol_l ^ phase_l);
    assign launch_clk = ~samp_clk;
    assign frame_rst_n = reset_n && !chip_select_n && periph_en;

    // Receive shifter, MSB first, word captured at the 16th bit
    always_ff @(posedge samp_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rx_shift_q <= 16'h0000;
            rx_cnt_q <= SPP_BIT_COUNT_RESET;
        end else begin
            rx_shift_q <= {rx_shift_q[14:0], peripheral_data_in};
            rx_cnt_q <= (rx_cnt_q == SPP_BIT_COUNT_LAST) ? SPP_BIT_COUNT_RESET
                        : rx_cnt_q + 5'h01;
        end
    end

    // Completed word and event toggle live past the frame
    always_ff @(posedge samp_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_word_q <= 16'h0000;
            rx_tgl_q <= 1'b0;
        end else if (frame_rst_n && rx_cnt_q == SPP_BIT_COUNT_LAST) begin
            rx_word_q <= {rx_shift_q[14:0], peripheral_data_in};
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // Transmit shifter: phase 1 presents MSB at select, phase 0 at first edge
    // Phase 1 sees a sample edge first, so its first launch moves on to bit 14
    always_ff @(posedge launch_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_shift_q <= 16'h0000;
            tx_cnt_q <= SPP_BIT_COUNT_RESET;
        end else begin
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == SPP_BIT_COUNT_RESET) begin
                if (phase_l) begin
                    tx_shift_q <= {tx_hold_q[14:0], 1'b0};
                end else begin
                    tx_shift_q <= tx_hold_q;
                end
            end else begin
                tx_shift_q <= {tx_shift_q[14:0], 1'b0};
            end
        end
    end

    // Output: phase 1 shows held word MSB before first launch
    always_comb begin
        if (phase_l && tx_cnt_q == SPP_BIT_COUNT_RESET) begin
            peripheral_data_out = tx_hold_q[15];
        end else begin
            peripheral_data_out = tx_shift_q[15];
        end
    end
    assign peripheral_data_out_oe = frame_rst_n;

    // Phase 0 loads the held word at the first launch edge too
    logic ph0_loaded_unused;
    assign ph0_loaded_unused = 1'b0;

    // Word taken toggle at frame start (select assertion)
    always_ff @(negedge chip_select_n or negedge reset_n) begin
        if (!reset_n) begin
            tx_take_tgl_q <= 1'b0;
        end else if (periph_en) begin
            tx_take_tgl_q <= ~tx_take_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System domain: transmit word holding and handshake crossing
    logic take_s;
    logic take_seen_q;
    logic tx_full_q;
    logic rx_t_s;
    logic rx_seen_q;
    logic push;
    logic push_ready;
    logic push_valid_q;
    logic [15:0] push_data_q;

    spp_sync u_sync_take (
        .clk(clk),
        .rst_n(rst_n_q),
        .level_in(tx_take_tgl_q),
        .level_out(take_s)
    );

    spp_sync u_sync_rx (
        .clk(clk),
        .rst_n(rst_n_q),
        .level_in(rx_tgl_q),
        .level_out(rx_t_s)
    );

    // Held word reloads whenever tx_valid finds the slot free; the slot frees at select assertion, so it can change during a frame
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_hold_q <= SPP_TX_IDLE_WORD;
            tx_full_q <= 1'b0;
            take_seen_q <= 1'b0;
        end else begin
            take_seen_q <= take_s;
            if (take_s != take_seen_q) begin
                tx_full_q <= 1'b0;
            end else if (tx_valid && !tx_full_q) begin
                tx_hold_q <= tx_data;
                tx_full_q <= 1'b1;
            end
        end
    end

    // Ready only when the holding slot is free
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= !tx_full_q && !(tx_valid && !tx_full_q)
                        && (take_s == take_seen_q);
        end
    end

    // Received word event: word is stable for many clocks after toggle
    assign push = rx_t_s != rx_seen_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_seen_q <= 1'b0;
            push_valid_q <= 1'b0;
            push_data_q <= 16'h0000;
            rx_overrun <= 1'b0;
        end else begin
            rx_seen_q <= rx_t_s;
            if (push) begin
                push_data_q <= rx_word_q;
                push_valid_q <= 1'b1;
                rx_overrun <= push_valid_q && !push_ready;
            end else if (push_ready) begin
                push_valid_q <= 1'b0;
            end
        end
    end

    // Peripheral-mode status flag
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            peripheral_active <= 1'b0;
        end else begin
            peripheral_active <= periph_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive FIFO
    logic [15:0] f_data;
    logic f_valid;

    spp_fifo #(
        .WIDTH(SPP_WORD_BITS),
        .DEPTH(SPP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n_q),
        .in_data(push_data_q),
        .in_valid(push_valid_q),
        .in_ready(push_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(rx_ready && rx_valid)
    );

    // Registered output stage, refilled when consumer takes word
    logic pop_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_valid <= 1'b0;
            rx_data <= 16'h0000;
        end else begin
            rx_valid <= f_valid && !(rx_ready && rx_valid);
            rx_data <= f_data;
        end
    end
    assign pop_q = unused_cfg & ph0_loaded_unused;
endmodule
`default_nettype wire

/* File: bench/spp_port_monitor.sv */
// Checker of the serial peripheral port outputs
`timescale 1ns/100ps
`default_nettype none
module spp_port_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode and link pins
    input wire logic ctl_controller_select,
    input wire logic fmt_clock_phase,
    input wire logic fmt_clock_polarity,
    input wire logic serial_clock_pin,
    input wire logic chip_select_n,
    input wire logic peripheral_data_out,
    input wire logic peripheral_data_out_oe,
    // Word handshakes and status
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [15:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_overrun,
    input wire logic peripheral_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Select released for two cycles
    sequence s_deselected;
        chip_select_n [*2];
    endsequence
    // Data out moves together with a clock edge while driven
    sequence s_launch;
        $changed(peripheral_data_out) && $changed(serial_clock_pin) && $past(peripheral_data_out_oe);
    endsequence
    property p_idle_quiet;
        s_deselected |-> !peripheral_data_out_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("data out driven while deselected");
    property p_mode_off;
        ctl_controller_select [*5] |-> !peripheral_active && !peripheral_data_out_oe;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("port active in controller mode");
    property p_launch_edge;
        s_launch |-> serial_clock_pin == (fmt_clock_polarity == fmt_clock_phase);
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("data out moved on sample edge");
    property p_tx_slot;
        tx_valid && tx_ready |=> !tx_ready;
    endproperty
    a_tx_slot: assert property (p_tx_slot) else $error("tx slot accepted twice");
    property p_rx_stands;
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_stands: assert property (p_rx_stands) else $error("received word not held");
    property p_overrun;
        $rose(rx_overrun) |-> rx_valid && !$past(rx_ready);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun without full buffer");
endmodule
////////////////////////////////
bind spp_port spp_port_monitor mon (.clk, .reset_n, .ctl_controller_select, .fmt_clock_phase,
    .fmt_clock_polarity, .serial_clock_pin, .chip_select_n, .peripheral_data_out,
    .peripheral_data_out_oe, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .rx_overrun, .peripheral_active);
`default_nettype wire

/* File: bench/spp_host.sv */
// Host model driving framed words as link controller
`timescale 1ns/100ps
`default_nettype none
module spp_host (
    // Link pins driven by the host
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    // Device answer and mode
    input wire logic miso,
    input wire logic pol,
    input wire logic pha
);
    localparam real HALF_NS = 15.0;
    // Pins idle at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // One framed word, MSB first, returning what came back
    task automatic frame(input logic [15:0] w, output logic [15:0] got);
        int s;
        s = 0;
        got = 16'h0000;
        sclk = pol;
        #3.3;
        cs_n = 1'b0;
        mosi = w[15];
        #(4 * HALF_NS);
        for (int e = 0; e < 32; e++) begin
            if (~sclk == (pol != pha)) begin
                got = {got[14:0], miso};
                s++;
                sclk = ~sclk;
            end else begin
                sclk = ~sclk;
                mosi = w[15 - (s % 16)];
            end
            #HALF_NS;
        end
        cs_n = 1'b1;
        mosi = ~mosi; // Released line shows no stale bit
        #(4 * HALF_NS);
    endtask
endmodule
`default_nettype wire

/* File: bench/spp_port_tb.sv */
// Testbench of the serial peripheral port
`timescale 1ns/100ps
`default_nettype none
module spp_port_tb;
    import spp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ctl_controller_select = 1'b0;
    logic fmt_clock_phase = 1'b0;
    logic fmt_clock_polarity = 1'b0;
    logic [7:0] prescale_value = 8'h02;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic serial_clock_pin, chip_select_n, peripheral_data_in, peripheral_data_out;
    logic peripheral_data_out_oe, tx_ready, rx_valid, rx_overrun, peripheral_active;
    logic [15:0] rx_data, got;
    int n_fail = 0;
    int checks = 0;
    // Rows: polarity, phase, word returned, word received
    logic [33:0] rows [4] = '{{2'b00, 16'ha55a, 16'h1234}, {2'b01, 16'h8001, 16'h7ffe},
        {2'b10, 16'hffff, 16'h0000}, {2'b11, 16'h0001, 16'h8000}};
    // System clock
    always #4 clk = ~clk;
    spp_port dut (.clk, .reset_n, .ctl_controller_select, .fmt_clock_phase, .fmt_clock_polarity,
        .prescale_value, .serial_clock_pin, .chip_select_n, .peripheral_data_in,
        .peripheral_data_out, .peripheral_data_out_oe, .tx_data, .tx_valid, .tx_ready,
        .rx_data, .rx_valid, .rx_ready, .rx_overrun, .peripheral_active);
    spp_host host (.sclk(serial_clock_pin), .cs_n(chip_select_n), .mosi(peripheral_data_in),
        .miso(peripheral_data_out), .pol(fmt_clock_polarity), .pha(fmt_clock_phase));
    ////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hand one word to the transmit slot
    task automatic put_tx(input logic [15:0] w);
        int n;
        @(posedge clk);
        tx_data <= w;
        tx_valid <= 1'b1;
        for (n = 0; n < 200 && tx_ready !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 200) begin
            check("tx_ready wait", 16'h0000, 16'h0001);
            test_done();
        end
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    // Take one received word and compare it
    task automatic get_rx(input logic [15:0] exp);
        int n;
        @(negedge clk);
        for (n = 0; n < 200 && rx_valid !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 200) begin
            check("rx_valid wait", 16'h0000, 16'h0001);
            test_done();
        end
        check("rx_data", rx_data, exp);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            {fmt_clock_polarity, fmt_clock_phase} <= rows[i][33:32];
            put_tx(rows[i][31:16]);
            repeat (8) @(posedge clk);
            host.frame(rows[i][15:0], got);
            check("data out word", got, rows[i][31:16]);
            get_rx(rows[i][15:0]);
            $display("mode row %0d done", i);
        end
        ctl_controller_select <= 1'b1;
        repeat (8) @(posedge clk);
        check("peripheral_active", {15'h0000, peripheral_active}, 16'h0000);
        host.frame(16'h5aa5, got);
        repeat (20) @(posedge clk);
        check("rx_valid", {15'h0000, rx_valid}, 16'h0000);
        ctl_controller_select <= 1'b0;
        repeat (8) @(posedge clk);
        check("peripheral_active", {15'h0000, peripheral_active}, 16'h0001);
        $display("controller mode test done");
        for (int i = 0; i < SPP_FIFO_DEPTH + 3; i++) begin
            @(posedge clk);
            host.frame(16'h0100 + 16'(i), got);
        end
        repeat (20) @(posedge clk);
        check("rx_overrun", {15'h0000, rx_overrun}, 16'h0001);
        get_rx(16'h0100);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("rx_overrun", {15'h0000, rx_overrun}, 16'h0000);
        check("rx_valid", {15'h0000, rx_valid}, 16'h0000);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("overrun and reset test done");
        put_tx(16'hc3c3);
        repeat (8) @(posedge clk);
        check("tx_ready", {15'h0000, tx_ready}, 16'h0000);
        host.frame(16'h0f0f, got);
        check("data out word", got, 16'hc3c3);
        get_rx(16'h0f0f);
        $display("refusal test done");
        test_done();
    end
endmodule
`default_nettype wire
